// file: design/ufc_top.sv
// AHB-Lite register file and RS-485 control for the UART feature block.
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "ufc_defs.svh"
module ufc_top #(
    parameter int FIFO_DEPTH = 64
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Line pins and interrupt
    input  wire logic        rxd,
    input  wire logic        cts,
    output logic             txd,
    output logic             irda_tx,
    output logic             rts,
    output logic             irq
);
    ufc_ctl_if ctl ();

    logic [7:0] efc_reg, divlo_reg, divhi_reg, enh_reg, ien_reg, fifoctl_reg, modem_reg;
    logic [7:0] trig_reg, xchr_reg;
    logic [1:0] rx_meta_reg, cts_meta_reg;
    logic       wr_pend_reg;
    logic [7:0] waddr_reg;
    logic [7:0] tx_cnt_reg, rx_cnt_reg;
    logic       fc_rts_reg;
    logic       special_flag_reg, address_flag_reg;
    logic [8:0] rx_last_reg;
    logic [31:0] hrdata_reg;

    // Two flip-flop synchronisers; only the second stage is read.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_meta_reg  <= 2'b11;
            cts_meta_reg <= 2'b00;
        end else begin
            rx_meta_reg  <= {rx_meta_reg[0], rxd};
            cts_meta_reg <= {cts_meta_reg[0], cts};
        end
    end

    // Bus decode: zero wait states, OKAY always.
    logic access, rd_now, wr_data;
    assign access    = hsel && hready && htrans[1];
    assign rd_now    = access && !hwrite;
    assign wr_data   = wr_pend_reg;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    logic        we_efc, we_divlo, we_divhi, we_enh, we_ien, we_fifo, we_modem;
    logic        we_trig, we_xchr, we_tx, sleep, enhance;
    logic [7:0]  wb;
    assign wb       = hwdata[7:0];
    assign sleep    = ien_reg[`UFC_BIT_SLEEP];
    assign enhance  = enh_reg[`UFC_BIT_ENHANCE];
    assign we_efc   = wr_data && waddr_reg == `UFC_OFF_EFC;
    assign we_divlo = wr_data && waddr_reg == `UFC_OFF_DIVLO && !sleep;
    assign we_divhi = wr_data && waddr_reg == `UFC_OFF_DIVHI && !sleep;
    assign we_enh   = wr_data && waddr_reg == `UFC_OFF_ENH;
    assign we_ien   = wr_data && waddr_reg == `UFC_OFF_IEN;
    assign we_fifo  = wr_data && waddr_reg == `UFC_OFF_FIFOCTL;
    assign we_modem = wr_data && waddr_reg == `UFC_OFF_MODEM;
    assign we_trig  = wr_data && waddr_reg == `UFC_OFF_TRIG;
    assign we_xchr  = wr_data && waddr_reg == `UFC_OFF_XCHR;
    assign we_tx    = wr_data && waddr_reg == `UFC_OFF_STATUS;

    // Guarded bits keep their value unless enhanced functions are enabled.
    function automatic logic [7:0] guard_merge(input logic [7:0] old, input logic [7:0] nw,
                                               input logic [7:0] msk, input logic en);
        guard_merge = en ? nw : ((old & msk) | (nw & ~msk));
    endfunction : guard_merge

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            waddr_reg   <= 8'h00;
        end else begin
            wr_pend_reg <= access && hwrite;
            waddr_reg   <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            efc_reg     <= 8'h00;
            divlo_reg   <= 8'(`UFC_DIV_RESET);
            divhi_reg   <= 8'h00;
            enh_reg     <= 8'h00;
            ien_reg     <= 8'h00;
            fifoctl_reg <= 8'h00;
            modem_reg   <= 8'h00;
            trig_reg    <= `UFC_TRIG_RESET;
            xchr_reg    <= 8'h00;
        end else begin
            if (we_efc)   efc_reg     <= wb & `UFC_EFC_MASK;
            if (we_divlo) divlo_reg   <= wb;
            if (we_divhi) divhi_reg   <= wb;
            if (we_enh)   enh_reg     <= wb;
            if (we_ien)   ien_reg     <= guard_merge(ien_reg, wb, `UFC_IEN_GUARD, enhance);
            if (we_fifo)  fifoctl_reg <= guard_merge(fifoctl_reg, wb, `UFC_FIFO_GUARD, enhance);
            if (we_modem) modem_reg   <= guard_merge(modem_reg, wb, `UFC_MODEM_GUARD, enhance);
            if (we_trig)  trig_reg    <= wb;
            if (we_xchr)  xchr_reg    <= wb;
        end
    end

    // Control bundle to the serial engine.
    assign ctl.divisor      = {divhi_reg, divlo_reg};
    assign ctl.irda_quarter = efc_reg[`UFC_BIT_IRDA];
    assign ctl.irda_en      = modem_reg[6];
    assign ctl.tx_off       = efc_reg[`UFC_BIT_TXOFF];
    assign ctl.rx_off       = efc_reg[`UFC_BIT_RXOFF];
    assign ctl.cts_fc       = enh_reg[`UFC_BIT_CTSFC];
    assign ctl.mdrop        = efc_reg[`UFC_BIT_MDROP];
    assign ctl.special      = enh_reg[`UFC_BIT_SPECIAL];
    assign ctl.special_chr  = xchr_reg;

    // Transmit and receive FIFO occupancy counters; transmit characters come from a write to the status offset.
    logic tx_take, tx_push, tx_full, rx_pop, rx_full;
    logic [8:0] tx_word_reg;
    assign tx_full = (tx_cnt_reg == 8'(FIFO_DEPTH));
    assign tx_push = we_tx && !tx_full;
    assign rx_full = (rx_cnt_reg == 8'(FIFO_DEPTH));
    assign rx_pop  = rd_now && haddr[7:0] == `UFC_OFF_STATUS && rx_cnt_reg != 8'h00;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_cnt_reg  <= 8'h00;
            rx_cnt_reg  <= 8'h00;
            tx_word_reg <= 9'h000;
            rx_last_reg <= 9'h000;
        end else begin
            tx_cnt_reg <= tx_cnt_reg + 8'(tx_push) - 8'(tx_take);
            rx_cnt_reg <= rx_cnt_reg + 8'(ctl.rx_push && !rx_full) - 8'(rx_pop);
            if (tx_push)
                tx_word_reg <= {hwdata[8], wb};
            if (ctl.rx_push)
                rx_last_reg <= ctl.rx_data;
        end
    end

    ufc_serial u_serial (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .ctl      (ctl.eng),
        .tx_valid (tx_cnt_reg != 8'h00),
        .tx_char  (tx_word_reg),
        .tx_take  (tx_take),
        .rx_sync  (rx_meta_reg[1]),
        .cts_sync (cts_meta_reg[1]),
        .txd      (txd),
        .irda_tx  (irda_tx)
    );

    // RTS flow control: halt level sets, resume level clears (levels in four-entry steps).
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            fc_rts_reg <= 1'b0;
        else if (rx_cnt_reg >= {2'b00, trig_reg[3:0], 2'b00})
            fc_rts_reg <= 1'b1;
        else if (rx_cnt_reg <= {2'b00, trig_reg[7:4], 2'b00})
            fc_rts_reg <= 1'b0;
    end

    // Transmitter-owned RTS outranks flow control and the modem bit.
    logic tx_active, rts_tx;
    assign tx_active = (tx_cnt_reg != 8'h00) || ctl.tx_busy;
    assign rts_tx    = tx_active ^ efc_reg[`UFC_BIT_RTSINV] ? 1'b0 : 1'b1;
    assign rts = efc_reg[`UFC_BIT_TXRTS] ? rts_tx :
                 enh_reg[`UFC_BIT_RTSFC] ? fc_rts_reg : !modem_reg[1];

    // Sticky event flags; a new event wins over the clear by register write.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            special_flag_reg <= 1'b0;
            address_flag_reg <= 1'b0;
        end else begin
            if (ctl.rx_special)
                special_flag_reg <= 1'b1;
            else if (we_enh)
                special_flag_reg <= 1'b0;
            if (ctl.rx_address)
                address_flag_reg <= 1'b1;
            else if (we_efc)
                address_flag_reg <= 1'b0;
        end
    end
    assign irq = address_flag_reg || special_flag_reg;

    // Read mux; unmapped offsets read zero.
    logic [31:0] rd_val;
    always_comb begin
        case (haddr[7:0])
            `UFC_OFF_EFC:     rd_val = {24'h000000, efc_reg};
            `UFC_OFF_DIVLO:   rd_val = {24'h000000, divlo_reg};
            `UFC_OFF_DIVHI:   rd_val = {24'h000000, divhi_reg};
            `UFC_OFF_ENH:     rd_val = {24'h000000, enh_reg};
            `UFC_OFF_IEN:     rd_val = {24'h000000, ien_reg};
            `UFC_OFF_FIFOCTL: rd_val = {24'h000000, fifoctl_reg};
            `UFC_OFF_MODEM:   rd_val = {24'h000000, modem_reg};
            `UFC_OFF_TRIG:    rd_val = {24'h000000, trig_reg};
            `UFC_OFF_XCHR:    rd_val = {24'h000000, xchr_reg};
            `UFC_OFF_STATUS:  rd_val = {special_flag_reg, tx_cnt_reg[6:0], address_flag_reg,
                                        rx_cnt_reg[6:0], 7'h00, rx_last_reg};
            default:          rd_val = 32'h00000000;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata_reg <= 32'h00000000;
        else if (rd_now)
            hrdata_reg <= rd_val;
    end

    // Assertions.
    property p_div_locked;
        @(posedge hclk) disable iff (!hresetn)
        sleep && wr_data && (waddr_reg == `UFC_OFF_DIVLO) |=> $stable(divlo_reg);
    endproperty
    a_div_locked: assert property (p_div_locked) else $error("divisor changed in sleep");

    property p_div_write;
        @(posedge hclk) disable iff (!hresetn)
        !sleep && wr_data && (waddr_reg == `UFC_OFF_DIVHI) |=> divhi_reg == $past(hwdata[7:0]);
    endproperty
    a_div_write: assert property (p_div_write) else $error("divisor high not written");

    property p_reserved;
        @(posedge hclk) disable iff (!hresetn) (efc_reg & 8'h48) == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    property p_guard;
        @(posedge hclk) disable iff (!hresetn)
        we_ien && !enhance |=> ien_reg[7:4] == $past(ien_reg[7:4]);
    endproperty
    a_guard: assert property (p_guard) else $error("guarded bits changed");

    property p_txoff;
        @(posedge hclk) disable iff (!hresetn) ctl.tx_off |-> !tx_take;
    endproperty
    a_txoff: assert property (p_txoff) else $error("start while disabled");

    property p_cts;
        @(posedge hclk) disable iff (!hresetn) ctl.cts_fc && cts_meta_reg[1] |-> !tx_take;
    endproperty
    a_cts: assert property (p_cts) else $error("start while CTS high");

    property p_rts_own;
        @(posedge hclk) disable iff (!hresetn)
        efc_reg[`UFC_BIT_TXRTS] && !efc_reg[`UFC_BIT_RTSINV] && tx_push |=> !rts;
    endproperty
    a_rts_own: assert property (p_rts_own) else $error("RTS not asserted on write");

    property p_special;
        @(posedge hclk) disable iff (!hresetn) ctl.rx_special |=> special_flag_reg;
    endproperty
    a_special: assert property (p_special) else $error("special flag missed");

    property p_addr;
        @(posedge hclk) disable iff (!hresetn) ctl.rx_address |=> irq;
    endproperty
    a_addr: assert property (p_addr) else $error("address interrupt missed");

    property p_rts_fc;
        @(posedge hclk) disable iff (!hresetn)
        enh_reg[`UFC_BIT_RTSFC] && !efc_reg[`UFC_BIT_TXRTS] && !we_enh && !we_efc &&
        (rx_cnt_reg >= {2'b00, trig_reg[3:0], 2'b00}) |=> rts;
    endproperty
    a_rts_fc: assert property (p_rts_fc) else $error("RTS not raised at halt level");
endmodule : ufc_top

// file: inc/ufc_defs.svh
// Register offsets, field positions, reset values and timing counts for the UART feature block.
// Operation
// - Bit 7 picks infrared pulse: 0 is 3/16 bit, 1 is quarter bit.
// - Bit 5 at 0: RTS low sending, high receiving; 1 swaps.
// - Bit 4 at 1 gives the transmitter the RTS pin; 0 gives none.
// - Bit 2 at 1 stops serial output; transmit FIFO still accepts writes.
// - A character already shifting finishes before the transmitter goes quiet.
// - Bit 1 stops the receiver at once; shifted character goes to FIFO; here it only blocks the next start and a character in progress completes.
// - Bit 0 selects RS-232 (0) or 9-bit multidrop RS-485 (1).
// - Sixteen-bit divisor: high register upper byte, low register lower byte.
// - Divisor written only while sleep enable bit 4 is clear.
// - CTS flow control stops transmission while CTS is high.
// - RTS flow control: high at halt level, low at resume level.
// - Special detect: match second stop character, store it, set identification bit 4; here it sets the status flag in bit 31 instead.
// - Enhanced bit 4 at 0 blocks writes to guarded enable, FIFO, modem bits.
// - Enhanced low nibble selects software flow control combinations; here the nibble is only stored and read back.
// - CTS, RTS flow control and special detect are off after reset.
// - Transmitter-owned RTS asserts on FIFO write, releases after last bit.
// - Multidrop: ninth bit set marks address character and raises interrupt.
`ifndef UFC_DEFS_SVH
`define UFC_DEFS_SVH
`define UFC_OFF_EFC      8'h00
`define UFC_OFF_DIVLO    8'h04
`define UFC_OFF_DIVHI    8'h08
`define UFC_OFF_ENH      8'h0c
`define UFC_OFF_IEN      8'h10
`define UFC_OFF_FIFOCTL  8'h14
`define UFC_OFF_MODEM    8'h18
`define UFC_OFF_TRIG     8'h1c
`define UFC_OFF_XCHR     8'h20
`define UFC_OFF_STATUS   8'h24
`define UFC_EFC_MASK     8'hb7
`define UFC_IEN_GUARD    8'hf0
`define UFC_FIFO_GUARD   8'h30
`define UFC_MODEM_GUARD  8'he0
`define UFC_BIT_IRDA     7
`define UFC_BIT_RTSINV   5
`define UFC_BIT_TXRTS    4
`define UFC_BIT_TXOFF    2
`define UFC_BIT_RXOFF    1
`define UFC_BIT_MDROP    0
`define UFC_BIT_CTSFC    7
`define UFC_BIT_RTSFC    6
`define UFC_BIT_SPECIAL  5
`define UFC_BIT_ENHANCE  4
`define UFC_BIT_SLEEP    4
`define UFC_DIV_RESET    16'h0001
`define UFC_TRIG_RESET   8'h00
`define UFC_OVS          16
`define UFC_IRDA_SHORT   3
`define UFC_IRDA_LONG    4
`endif

// file: inc/ufc_pkg.sv
// Types shared by the UART feature block.
package ufc_pkg;
    typedef enum logic [1:0] {
        UFC_TX_IDLE  = 2'b00,
        UFC_TX_SHIFT = 2'b01,
        UFC_TX_LAST  = 2'b11
    } ufc_tx_state_t;
endpackage : ufc_pkg

// file: inc/ufc_ctl_if.sv
// Control bundle between the register file and the serial engine.
`timescale 1ns/1ns
interface ufc_ctl_if;
    logic [15:0] divisor;
    logic        irda_quarter;
    logic        irda_en;
    logic        tx_off;
    logic        rx_off;
    logic        cts_fc;
    logic        mdrop;
    logic        special;
    logic [7:0]  special_chr;
    logic        tx_busy;
    logic        rx_push;
    logic [8:0]  rx_data;
    logic        rx_special;
    logic        rx_address;
    logic        tick16;
    modport regs (output divisor, irda_quarter, irda_en, tx_off, rx_off, cts_fc, mdrop,
                  special, special_chr,
                  input tx_busy, rx_push, rx_data, rx_special, rx_address, tick16);
    modport eng  (input divisor, irda_quarter, irda_en, tx_off, rx_off, cts_fc, mdrop,
                  special, special_chr,
                  output tx_busy, rx_push, rx_data, rx_special, rx_address, tick16);
endinterface : ufc_ctl_if

// file: design/ufc_serial.sv
// Serial engine: baud divider, transmit shifter with infrared pulse, receive sampler.
`timescale 1ns/1ns
`include "ufc_defs.svh"
module ufc_serial (
    // Clock and reset
    input  wire logic  hclk,
    input  wire logic  hresetn,
    // Controls
    ufc_ctl_if.eng     ctl,
    // Transmit request
    input  wire logic  tx_valid,
    input  wire logic [8:0] tx_char,
    output logic       tx_take,
    // Line
    input  wire logic  rx_sync,
    input  wire logic  cts_sync,
    output logic       txd,
    output logic       irda_tx
);
    logic [15:0] div_cnt_reg;
    logic [3:0]  sub_reg;
    logic [10:0] tx_sh_reg;
    logic [3:0]  tx_bits_reg;
    ufc_pkg::ufc_tx_state_t tx_st_reg;
    logic        rx_act_reg;
    logic [3:0]  rx_sub_reg;
    logic [3:0]  rx_bits_reg;
    logic [9:0]  rx_sh_reg;
    logic        tick;
    logic        bit_end;
    logic        can_start;
    logic [3:0]  pulse_len;
    logic [3:0]  nbits;
    logic        rx_done;

    assign tick      = (div_cnt_reg <= 16'h0001);
    assign bit_end   = tick && (sub_reg == 4'hf);
    assign ctl.tick16 = tick;
    // Transmitter holds off when disabled or CTS is high under flow control.
    assign can_start = tx_valid && !ctl.tx_off && !(ctl.cts_fc && cts_sync);
    assign tx_take   = bit_end && (tx_st_reg == ufc_pkg::UFC_TX_IDLE) && can_start;
    assign ctl.tx_busy = (tx_st_reg != ufc_pkg::UFC_TX_IDLE);
    assign txd       = (tx_st_reg == ufc_pkg::UFC_TX_IDLE) ? 1'b1 : tx_sh_reg[0];
    assign pulse_len = ctl.irda_quarter ? 4'(`UFC_IRDA_LONG) : 4'(`UFC_IRDA_SHORT);
    assign irda_tx   = ctl.irda_en && !txd && (sub_reg < pulse_len);
    assign nbits     = ctl.mdrop ? 4'hb : 4'ha;
    assign rx_done   = rx_act_reg && tick && (rx_sub_reg == 4'h7) && (rx_bits_reg == nbits - 4'h1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt_reg <= 16'h0000;
            sub_reg     <= 4'h0;
        end else begin
            div_cnt_reg <= tick ? ctl.divisor : div_cnt_reg - 16'h0001;
            if (tick)
                sub_reg <= sub_reg + 4'h1;
        end
    end

    // A started character always runs to its stop bit; disabling only blocks the next start.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_st_reg   <= ufc_pkg::UFC_TX_IDLE;
            tx_sh_reg   <= 11'h7ff;
            tx_bits_reg <= 4'h0;
        end else if (bit_end) begin
            case (tx_st_reg)
                ufc_pkg::UFC_TX_IDLE: if (tx_take) begin
                    tx_sh_reg   <= ctl.mdrop ? {1'b1, tx_char, 1'b0} : {2'b11, tx_char[7:0], 1'b0};
                    tx_bits_reg <= nbits - 4'h1;
                    tx_st_reg   <= ufc_pkg::UFC_TX_SHIFT;
                end
                ufc_pkg::UFC_TX_SHIFT: begin
                    tx_sh_reg   <= {1'b1, tx_sh_reg[10:1]};
                    tx_bits_reg <= tx_bits_reg - 4'h1;
                    if (tx_bits_reg == 4'h1)
                        tx_st_reg <= ufc_pkg::UFC_TX_LAST;
                end
                ufc_pkg::UFC_TX_LAST: tx_st_reg <= ufc_pkg::UFC_TX_IDLE;
                default: tx_st_reg <= ufc_pkg::UFC_TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_act_reg  <= 1'b0;
            rx_sub_reg  <= 4'h0;
            rx_bits_reg <= 4'h0;
            rx_sh_reg   <= 10'h000;
        end else if (!rx_act_reg) begin
            if (!ctl.rx_off && !rx_sync && tick) begin
                rx_act_reg  <= 1'b1;
                rx_sub_reg  <= 4'h0;
                rx_bits_reg <= 4'h0;
            end
        end else if (tick) begin
            rx_sub_reg <= rx_sub_reg + 4'h1;
            if (rx_sub_reg == 4'h7) begin
                rx_sh_reg   <= {rx_sync, rx_sh_reg[9:1]};
                rx_bits_reg <= rx_bits_reg + 4'h1;
                if (rx_done)
                    rx_act_reg <= 1'b0;
            end
        end
    end

    // At the stop-bit sample the data bits already sit in the top of the shift register.
    logic [8:0] rx_word;
    assign rx_word = ctl.mdrop ? rx_sh_reg[9:1] : {1'b0, rx_sh_reg[9:2]};
    // Receive-off only blocks a new start; a character being sampled runs to its stop bit and is pushed.
    assign ctl.rx_push    = rx_done;
    assign ctl.rx_data    = rx_word;
    assign ctl.rx_address = rx_done && ctl.mdrop && rx_sh_reg[9];
    assign ctl.rx_special = rx_done && ctl.special && (ctl.rx_data[7:0] == ctl.special_chr);
endmodule : ufc_serial

// file: tb/ufc_station.sv
// Remote serial station that drives the receive line and samples the transmit line.
`timescale 1ns/1ns
module ufc_station (
    // Clock
    input  wire logic hclk,
    // Line
    input  wire logic txd,
    output logic      rxd,
    output logic      cts
);
    int bt = 16;
    initial begin
        rxd = 1'b1;
        cts = 1'b0;
    end
    task automatic send(input logic [8:0] c, input int nb);
        rxd <= 1'b0;
        repeat (bt) @(posedge hclk);
        for (int i = 0; i < nb; i++) begin
            rxd <= c[i];
            repeat (bt) @(posedge hclk);
        end
        rxd <= 1'b1;
        repeat (bt) @(posedge hclk);
    endtask : send
    // Samples at mid-bit so a small skew in the design's divider still reads cleanly.
    task automatic recv(input int lim, output logic [7:0] c, output logic ok);
        int n;
        n = 0;
        c = 8'h00;
        while (txd !== 1'b0 && n < lim) begin
            @(posedge hclk);
            n++;
        end
        ok = (txd === 1'b0);
        if (ok) begin
            repeat (bt / 2) @(posedge hclk);
            for (int i = 0; i < 8; i++) begin
                repeat (bt) @(posedge hclk);
                c[i] = txd;
            end
            repeat (2 * bt) @(posedge hclk);
        end
    endtask : recv
endmodule : ufc_station

// file: tb/testbench.sv
// Self-checking bench for the UART feature block.
`timescale 1ns/1ns
`include "ufc_defs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        rxd, cts, txd, irda_tx, rts, irq, ok;
    logic [7:0]  ch;
    int          fail_count = 0;
    int          comparisons = 0;
    assign hready = hreadyout;
    ufc_top #(.FIFO_DEPTH(64)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .rxd(rxd), .cts(cts), .txd(txd), .irda_tx(irda_tx), .rts(rts), .irq(irq));
    ufc_station i_station (.hclk(hclk), .txd(txd), .rxd(rxd), .cts(cts));
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        haddr  <= {24'h000000, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [8:0] d);
        bus(1'b1, a, {23'h000000, d});
    endtask : wr
    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 32'h00000000);
        `CHK(rd[7:0], e)
    endtask : chk
    task automatic t_regs();
        chk(`UFC_OFF_ENH, 8'h00);
        wr(`UFC_OFF_EFC, 9'h0ff);
        chk(`UFC_OFF_EFC, 8'hb7);
        wr(`UFC_OFF_EFC, 9'h000);
        wr(`UFC_OFF_DIVLO, 9'h002);
        wr(`UFC_OFF_DIVHI, 9'h003);
        chk(`UFC_OFF_DIVHI, 8'h03);
        wr(`UFC_OFF_DIVHI, 9'h000);
        wr(`UFC_OFF_IEN, 9'h0f0);
        chk(`UFC_OFF_IEN, 8'h00);
        wr(`UFC_OFF_ENH, 9'h01f);
        chk(`UFC_OFF_ENH, 8'h1f);
        wr(`UFC_OFF_IEN, 9'h010);
        chk(`UFC_OFF_IEN, 8'h10);
        wr(`UFC_OFF_DIVLO, 9'h07e);
        chk(`UFC_OFF_DIVLO, 8'h02);
        wr(`UFC_OFF_IEN, 9'h000);
        i_station.bt = 32;
        // The divider may still count down the large value loaded while the high byte was set.
        repeat (800) @(posedge hclk);
    endtask : t_regs
    // Rows: RTS left alone, transmitter owned, transmitter owned and inverted.
    task automatic t_tx();
        logic [7:0] efc[3] = '{8'h00, 8'h10, 8'h30};
        logic       dur[3] = '{1'b1, 1'b0, 1'b1};
        for (int k = 0; k < 3; k++) begin
            wr(`UFC_OFF_EFC, {1'b0, efc[k]});
            wr(`UFC_OFF_STATUS, 9'h0a5);
            repeat (2) @(posedge hclk);
            `CHK(rts, dur[k])
            i_station.recv(400, ch, ok);
            `CHK(ch, 8'ha5)
            `CHK(rts, (k == 1) ? 1'b1 : dur[k] ^ (k == 2))
        end
        wr(`UFC_OFF_EFC, 9'h004);
        wr(`UFC_OFF_STATUS, 9'h05a);
        i_station.recv(400, ch, ok);
        `CHK(ok, 1'b0)
        wr(`UFC_OFF_EFC, 9'h000);
        i_station.recv(400, ch, ok);
        `CHK(ch, 8'h5a)
        wr(`UFC_OFF_ENH, 9'h080);
        i_station.cts <= 1'b1;
        wr(`UFC_OFF_STATUS, 9'h066);
        i_station.recv(400, ch, ok);
        `CHK(ok, 1'b0)
        i_station.cts <= 1'b0;
        i_station.recv(400, ch, ok);
        `CHK(ch, 8'h66)
    endtask : t_tx
    task automatic t_irda();
        int n, w;
        wr(`UFC_OFF_ENH, 9'h010);
        wr(`UFC_OFF_MODEM, 9'h040);
        for (int q = 0; q < 2; q++) begin
            wr(`UFC_OFF_EFC, {1'b0, q[0], 7'h00});
            wr(`UFC_OFF_STATUS, 9'h000);
            n = 0;
            w = 0;
            while (irda_tx !== 1'b1 && w < 400) begin
                @(posedge hclk);
                w++;
            end
            while (irda_tx === 1'b1 && n < 40) begin
                @(posedge hclk);
                n++;
            end
            `CHK(n, (q == 1) ? 8 : 6)
            i_station.recv(400, ch, ok);
        end
        wr(`UFC_OFF_MODEM, 9'h000);
        wr(`UFC_OFF_EFC, 9'h000);
    endtask : t_irda
    // Receive-off is only ever set while the line is idle.
    task automatic t_rx();
        wr(`UFC_OFF_ENH, 9'h020);
        wr(`UFC_OFF_XCHR, 9'h03c);
        i_station.send(9'h03d, 8);
        `CHK(irq, 1'b0)
        i_station.send(9'h03c, 8);
        `CHK(irq, 1'b1)
        wr(`UFC_OFF_ENH, 9'h000);
        wr(`UFC_OFF_EFC, 9'h003);
        i_station.send(9'h1a5, 9);
        `CHK(irq, 1'b0)
        wr(`UFC_OFF_EFC, 9'h001);
        i_station.send(9'h0a5, 9);
        `CHK(irq, 1'b0)
        i_station.send(9'h1a5, 9);
        `CHK(irq, 1'b1)
    endtask : t_rx
    // Halt level at four entries, resume level at none; four characters wait in the FIFO.
    task automatic t_fc();
        wr(`UFC_OFF_TRIG, 9'h001);
        wr(`UFC_OFF_ENH, 9'h040);
        @(posedge hclk);
        `CHK(rts, 1'b1)
        bus(1'b0, `UFC_OFF_STATUS, 32'h00000000);
        `CHK(rd, 32'h008401a5)
        repeat (3) bus(1'b0, `UFC_OFF_STATUS, 32'h00000000);
        @(posedge hclk);
        `CHK(rts, 1'b0)
    endtask : t_fc
    task automatic test_done();
        $display("Mismatches %0d, comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done
    initial begin
        {hresetn, haddr, htrans, hwrite, hwdata} = '0;
        hsel = 1'b1;
        hsize = 3'b010;
        repeat (16) @(posedge hclk);
        `CHK({rts, txd, irq}, 3'b110)
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_tx();
        t_irda();
        t_rx();
        t_fc();
        test_done();
    end
    initial begin
        repeat (60000) @(posedge hclk);
        fail_count++;
        test_done();
    end
endmodule : testbench
